// File: hw/lscc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "lscc_map.vh"

// Summary of operation
// - Quick wake keeps circuits powered in standby, only in one-shot states.
// - Full-scale code 0..8 picks a doubling range; code 12 is auto-range.
// - Period code 0..11 selects 600us up to 800ms conversion time.
// - Operating state: power-down, forced auto one-shot, one-shot, continuous.
// - Report style bit picks latched or transparent threshold reporting; resets to 1.
// - Polarity bit makes the interrupt pin active low or active high.
// - Persistence code needs 1, 2, 4 or 8 consecutive faults.
// - Event select: alert, every conversion, every fourth conversion; code 2 invalid.
// - With burst set, the read pointer advances by one after each register read.
// - Above-limit flag sets after enough consecutive results over the high threshold.
// - Below-limit flag sets after enough consecutive results under the low threshold.
module lscc_top (
    input wire sys_clk,
    input wire rst_b,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    input wire irq_in,
    output reg irq_out,
    output wire irq_oe,
    input wire conv_done,
    input wire [`LSCC_VAL_W-1:0] result_value,
    input wire [`LSCC_VAL_W-1:0] thresh_high,
    input wire [`LSCC_VAL_W-1:0] thresh_low,
    input wire flag_clear,
    input wire [`LSCC_REG_W-1:0] ext_rd_data,
    output wire [`LSCC_PTR_W-1:0] reg_pointer,
    output reg ext_rd_strobe,
    output reg ext_wr_strobe,
    output wire [`LSCC_REG_W-1:0] ext_wr_data,
    output wire [3:0] full_scale_select,
    output wire auto_range,
    output wire [3:0] integration_period_sel,
    output wire [1:0] op_state_select,
    output reg conv_start,
    output wire standby_keep_powered,
    output wire flag_high,
    output wire flag_low
);

    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_PTR = 3'h2;
    localparam ST_WDATA = 3'h3;
    localparam ST_ACK = 3'h4;
    localparam ST_RD = 3'h5;
    localparam ST_MACK = 3'h6;
    localparam integer PULSE_CYC = `LSCC_IRQ_PULSE_CYC;

    reg rst_m_q;
    reg rst_n_q;
    reg scl_m_q, scl_s_q, scl_p_q;
    reg sda_m_q, sda_s_q, sda_p_q;
    reg irq_m_q, irq_s_q, irq_p_q;
    reg [`LSCC_REG_W-1:0] cfg_q;
    reg [`LSCC_REG_W-1:0] irqc_q;
    reg [`LSCC_PTR_W-1:0] ptr_q;
    reg [2:0] st_q;
    reg [2:0] next_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;
    reg [7:0] msb_q;
    reg lsb_phase_q;
    reg sda_drive_q;
    reg [`LSCC_REG_W-1:0] wdata_q;
    reg [1:0] conv_cnt_q;
    reg [`LSCC_PULSE_W-1:0] pulse_q;
    wire rst_n;
    wire scl_rise, scl_fall, start_cond, stop_cond;
    wire [`LSCC_REG_W-1:0] rd_word;
    wire [7:0] byte_in;
    wire status_high, status_low;
    wire [1:0] irq_event;
    wire one_shot_state, new_one_shot;
    wire trig_level, trig_edge;
    reg irq_active;

    assign rst_n = rst_n_q;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_m_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n_q <= rst_m_q;
        end
    end

    // Pins pass two flip-flops; the third stage only feeds the edge detectors.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            irq_m_q <= 1'b1;
            irq_s_q <= 1'b1;
            irq_p_q <= 1'b1;
        end else begin
            scl_m_q <= scl_in;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_in;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            irq_m_q <= irq_in;
            irq_s_q <= irq_m_q;
            irq_p_q <= irq_s_q;
        end
    end

    assign scl_rise = scl_s_q && !scl_p_q;
    assign scl_fall = !scl_s_q && scl_p_q;
    assign start_cond = scl_s_q && scl_p_q && !sda_s_q && sda_p_q;
    assign stop_cond = scl_s_q && scl_p_q && sda_s_q && !sda_p_q;
    assign byte_in = sh_q;

    assign rd_word = (ptr_q == `LSCC_PTR_CFG) ? cfg_q :
                     (ptr_q == `LSCC_PTR_IRQ) ? irqc_q : ext_rd_data;

    // Reserved bits are stored as written; keeping them legal is the host's job.
    assign reg_pointer = ptr_q;
    assign ext_wr_data = wdata_q;
    assign sda_out = 1'b0;
    assign sda_oe = sda_drive_q;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            next_q <= ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            msb_q <= 8'h00;
            lsb_phase_q <= 1'b0;
            sda_drive_q <= 1'b0;
            ptr_q <= {`LSCC_PTR_W{1'b0}};
            cfg_q <= `LSCC_CFG_RST;
            irqc_q <= `LSCC_IRQ_RST;
            wdata_q <= {`LSCC_REG_W{1'b0}};
            ext_rd_strobe <= 1'b0;
            ext_wr_strobe <= 1'b0;
        end else begin
            ext_rd_strobe <= 1'b0;
            ext_wr_strobe <= 1'b0;
            if (start_cond) begin
                st_q <= ST_ADDR;
                bit_q <= 4'h0;
                lsb_phase_q <= 1'b0;
                sda_drive_q <= 1'b0;
            end else if (stop_cond) begin
                st_q <= ST_IDLE;
                sda_drive_q <= 1'b0;
            end else begin
                case (st_q)
                    ST_ADDR, ST_PTR, ST_WDATA: begin
                        if (scl_rise && bit_q != `LSCC_BIT_LAST) begin
                            sh_q <= {sh_q[6:0], sda_s_q};
                            bit_q <= bit_q + 4'h1;
                        end else if (scl_fall && bit_q == `LSCC_BIT_LAST) begin
                            bit_q <= 4'h0;
                            if (st_q == ST_ADDR) begin
                                if (byte_in[7:1] == `LSCC_DEV_ADDR) begin
                                    sda_drive_q <= 1'b1;
                                    lsb_phase_q <= 1'b0;
                                    next_q <= byte_in[0] ? ST_RD : ST_PTR;
                                    st_q <= ST_ACK;
                                end else begin
                                    st_q <= ST_IDLE;
                                end
                            end else if (st_q == ST_PTR) begin
                                ptr_q <= byte_in;
                                sda_drive_q <= 1'b1;
                                next_q <= ST_WDATA;
                                st_q <= ST_ACK;
                            end else begin
                                sda_drive_q <= 1'b1;
                                next_q <= ST_WDATA;
                                st_q <= ST_ACK;
                                lsb_phase_q <= !lsb_phase_q;
                                if (!lsb_phase_q) begin
                                    msb_q <= byte_in;
                                end else if (ptr_q == `LSCC_PTR_CFG) begin
                                    cfg_q <= {msb_q, byte_in};
                                end else if (ptr_q == `LSCC_PTR_IRQ) begin
                                    irqc_q <= {msb_q, byte_in};
                                end else begin
                                    wdata_q <= {msb_q, byte_in};
                                    ext_wr_strobe <= 1'b1;
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            st_q <= next_q;
                            bit_q <= 4'h0;
                            if (next_q == ST_RD) begin
                                sh_q <= lsb_phase_q ? rd_word[7:0] : rd_word[15:8];
                                sda_drive_q <= lsb_phase_q ? !rd_word[7] : !rd_word[15];
                            end else begin
                                sda_drive_q <= 1'b0;
                            end
                        end
                    end
                    ST_RD: begin
                        if (scl_fall) begin
                            if (bit_q == 4'h7) begin
                                sda_drive_q <= 1'b0;
                                st_q <= ST_MACK;
                                bit_q <= 4'h0;
                                if (lsb_phase_q) begin
                                    ext_rd_strobe <= 1'b1;
                                    if (irqc_q[`LSCC_IRQ_BURST]) begin
                                        ptr_q <= ptr_q + 8'h01;
                                    end
                                end
                                lsb_phase_q <= !lsb_phase_q;
                            end else begin
                                sh_q <= {sh_q[6:0], 1'b0};
                                sda_drive_q <= !sh_q[6];
                                bit_q <= bit_q + 4'h1;
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            next_q <= sda_s_q ? ST_IDLE : ST_RD;
                        end else if (scl_fall) begin
                            st_q <= (next_q == ST_RD) ? ST_RD : ST_IDLE;
                            bit_q <= 4'h0;
                            if (next_q == ST_RD) begin
                                sh_q <= lsb_phase_q ? rd_word[7:0] : rd_word[15:8];
                                sda_drive_q <= lsb_phase_q ? !rd_word[7] : !rd_word[15];
                            end
                        end
                    end
                    default: begin
                        st_q <= ST_IDLE;
                        sda_drive_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign full_scale_select = cfg_q[`LSCC_CFG_FS_HI:`LSCC_CFG_FS_LO];
    assign integration_period_sel = cfg_q[`LSCC_CFG_TP_HI:`LSCC_CFG_TP_LO];
    assign op_state_select = cfg_q[`LSCC_CFG_OP_HI:`LSCC_CFG_OP_LO];
    assign one_shot_state = (op_state_select == `LSCC_OP_FORCED) ||
                            (op_state_select == `LSCC_OP_ONESHOT);
    // The forced one-shot state overrides a fixed range choice.
    assign auto_range = (full_scale_select == `LSCC_FS_AUTO) ||
                        (op_state_select == `LSCC_OP_FORCED);
    assign standby_keep_powered = cfg_q[`LSCC_CFG_QUICK_WAKE] && one_shot_state;
    assign irq_event = irqc_q[`LSCC_IRQ_EV_HI:`LSCC_IRQ_EV_LO];
    assign irq_oe = irqc_q[`LSCC_IRQ_DIR];

    // As an input the pin is read at the programmed active level.
    assign trig_level = irq_s_q ~^ cfg_q[`LSCC_CFG_POL];
    assign trig_edge = trig_level && !(irq_p_q ~^ cfg_q[`LSCC_CFG_POL]);

    // A one-shot starts on a trigger at the pin or on a configuration write selecting one.
    // The written byte is decoded, since the register itself changes on this same edge.
    assign new_one_shot = (byte_in[`LSCC_CFG_OP_HI:`LSCC_CFG_OP_LO] == `LSCC_OP_FORCED) ||
                          (byte_in[`LSCC_CFG_OP_HI:`LSCC_CFG_OP_LO] == `LSCC_OP_ONESHOT);
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= (one_shot_state && !irq_oe && trig_edge) ||
                          (scl_fall && st_q == ST_WDATA && bit_q == `LSCC_BIT_LAST &&
                           lsb_phase_q && ptr_q == `LSCC_PTR_CFG && new_one_shot);
        end
    end

    lscc_persist u_persist (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sample(conv_done),
        .above(result_value > thresh_high),
        .below(result_value < thresh_low),
        .count_code(cfg_q[`LSCC_CFG_PC_HI:`LSCC_CFG_PC_LO]),
        .flag_clear(flag_clear),
        .flag_high_q(flag_high),
        .flag_low_q(flag_low),
        .status_high(status_high),
        .status_low(status_low)
    );

    // Conversion-driven pulses are fixed width so a slow host can still see them.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_cnt_q <= 2'h0;
            pulse_q <= {`LSCC_PULSE_W{1'b0}};
        end else begin
            if (conv_done) begin
                conv_cnt_q <= conv_cnt_q + 2'h1;
            end
            if (conv_done && (irq_event == `LSCC_EV_EVERY ||
                (irq_event == `LSCC_EV_FOURTH && conv_cnt_q == `LSCC_EV_GROUP))) begin
                pulse_q <= PULSE_CYC[`LSCC_PULSE_W-1:0];
            end else if (pulse_q != {`LSCC_PULSE_W{1'b0}}) begin
                pulse_q <= pulse_q - 1'b1;
            end
        end
    end

    always @* begin
        case (irq_event)
            `LSCC_EV_ALERT: begin
                irq_active = cfg_q[`LSCC_CFG_LATCH] ? (flag_high || flag_low) :
                             (status_high || status_low);
            end
            `LSCC_EV_EVERY, `LSCC_EV_FOURTH: begin
                irq_active = (pulse_q != {`LSCC_PULSE_W{1'b0}});
            end
            default: begin
                irq_active = 1'b0;
            end
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_out <= 1'b1;
        end else begin
            irq_out <= cfg_q[`LSCC_CFG_POL] ? irq_active : !irq_active;
        end
    end

endmodule

`default_nettype wire

// File: hw/lscc_map.vh
`ifndef LSCC_MAP_VH
`define LSCC_MAP_VH

// Register pointer values.
`define LSCC_PTR_W 8
`define LSCC_PTR_CFG 8'h0a
`define LSCC_PTR_IRQ 8'h0b
`define LSCC_REG_W 16

// Reset values.
`define LSCC_CFG_RST 16'h3208
`define LSCC_IRQ_RST 16'h8011

// Fields of the sensor configuration register.
`define LSCC_CFG_QUICK_WAKE 15
`define LSCC_CFG_FS_HI 13
`define LSCC_CFG_FS_LO 10
`define LSCC_CFG_TP_HI 9
`define LSCC_CFG_TP_LO 6
`define LSCC_CFG_OP_HI 5
`define LSCC_CFG_OP_LO 4
`define LSCC_CFG_LATCH 3
`define LSCC_CFG_POL 2
`define LSCC_CFG_PC_HI 1
`define LSCC_CFG_PC_LO 0

// Fields of the interrupt and burst configuration register.
`define LSCC_IRQ_DIR 4
`define LSCC_IRQ_EV_HI 3
`define LSCC_IRQ_EV_LO 2
`define LSCC_IRQ_BURST 0

// Encodings.
`define LSCC_FS_AUTO 4'hc
`define LSCC_FS_MAX 4'h8
`define LSCC_TP_MAX 4'hb
`define LSCC_OP_DOWN 2'h0
`define LSCC_OP_FORCED 2'h1
`define LSCC_OP_ONESHOT 2'h2
`define LSCC_OP_CONT 2'h3
`define LSCC_EV_ALERT 2'h0
`define LSCC_EV_EVERY 2'h1
`define LSCC_EV_BAD 2'h2
`define LSCC_EV_FOURTH 2'h3
`define LSCC_EV_GROUP 2'h3

// Comparison value width and persistence counter width.
`define LSCC_VAL_W 20
`define LSCC_PC_W 4

// Serial bus constants.
`define LSCC_DEV_ADDR 7'h44
`define LSCC_BIT_LAST 4'h8

// Interrupt pulse width: time in ns and cycles at 50 MHz (rounded down).
`define LSCC_CLK_NS 20
`define LSCC_IRQ_PULSE_NS 1000
`define LSCC_IRQ_PULSE_CYC (`LSCC_IRQ_PULSE_NS / `LSCC_CLK_NS)
`define LSCC_PULSE_W 6

`endif

// File: hw/lscc_persist.v
`timescale 1ns/1ps
`default_nettype none
`include "lscc_map.vh"

module lscc_persist (
    input wire sys_clk,
    input wire rst_n,
    input wire sample,
    input wire above,
    input wire below,
    input wire [1:0] count_code,
    input wire flag_clear,
    output reg flag_high_q,
    output reg flag_low_q,
    output wire status_high,
    output wire status_low
);

    reg [`LSCC_PC_W-1:0] run_high_q;
    reg [`LSCC_PC_W-1:0] run_low_q;
    wire [`LSCC_PC_W-1:0] need;
    wire [`LSCC_PC_W-1:0] run_high_d;
    wire [`LSCC_PC_W-1:0] run_low_d;

    // Codes 0..3 need 1, 2, 4 and 8 consecutive faults.
    assign need = {{(`LSCC_PC_W-1){1'b0}}, 1'b1} << count_code;

    // Runs saturate at the required count so a long fault never wraps.
    assign run_high_d = !above ? {`LSCC_PC_W{1'b0}} :
                        (run_high_q >= need) ? need : run_high_q + 1'b1;
    assign run_low_d = !below ? {`LSCC_PC_W{1'b0}} :
                       (run_low_q >= need) ? need : run_low_q + 1'b1;

    assign status_high = (run_high_q >= need);
    assign status_low = (run_low_q >= need);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_high_q <= {`LSCC_PC_W{1'b0}};
            run_low_q <= {`LSCC_PC_W{1'b0}};
            flag_high_q <= 1'b0;
            flag_low_q <= 1'b0;
        end else begin
            if (sample) begin
                run_high_q <= run_high_d;
                run_low_q <= run_low_d;
            end
            // A new hit in the clearing cycle keeps the flag set.
            if (sample && above && run_high_d >= need) begin
                flag_high_q <= 1'b1;
            end else if (flag_clear) begin
                flag_high_q <= 1'b0;
            end
            if (sample && below && run_low_d >= need) begin
                flag_low_q <= 1'b1;
            end else if (flag_clear) begin
                flag_low_q <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// File: bench/lscc_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lscc_checker (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic conv_done,
    input wire logic [19:0] result_value,
    input wire logic [19:0] thresh_high,
    input wire logic [19:0] thresh_low,
    input wire logic flag_clear,
    input wire logic [3:0] full_scale_select,
    input wire logic auto_range,
    input wire logic [1:0] op_state_select,
    input wire logic conv_start,
    input wire logic standby_keep_powered,
    input wire logic flag_high,
    input wire logic flag_low
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    a_auto_range_map: assert property (
        auto_range == (full_scale_select == 4'hc || op_state_select == 2'h1))
        else $error("Auto range output disagrees with the range and state fields.");
    a_quick_wake_state: assert property (
        standby_keep_powered |-> op_state_select inside {2'h1, 2'h2})
        else $error("Partial standby outside the one-shot states.");
    a_start_single: assert property (
        conv_start |=> !conv_start)
        else $error("Conversion start is longer than one cycle.");
    a_start_one_shot: assert property (
        conv_start |-> op_state_select inside {2'h1, 2'h2})
        else $error("Conversion start outside the one-shot states.");
    a_high_flag_cause: assert property (
        $rose(flag_high) |-> $past(conv_done) && $past(result_value) > $past(thresh_high))
        else $error("High flag rose without a result above the threshold.");
    a_low_flag_cause: assert property (
        $rose(flag_low) |-> $past(conv_done) && $past(result_value) < $past(thresh_low))
        else $error("Low flag rose without a result below the threshold.");
    a_flags_stay_set: assert property (
        !flag_clear |=> (!$past(flag_high) || flag_high) && (!$past(flag_low) || flag_low))
        else $error("A limit flag dropped without a clear.");
    a_clear_drops_flags: assert property (
        flag_clear && !conv_done |=> !flag_high && !flag_low)
        else $error("A limit flag survived a clear.");
endmodule
`default_nettype wire

// File: bench/lscc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "lscc_map.vh"
module lscc_host_model (
    input wire logic sys_clk,
    input wire logic sda_oe,
    output var logic scl_in,
    output wire logic sda_in
);
    logic sda_drv_q = 1'b1;
    logic nack_q = 1'b0;
    // The line has a pull-up, so it reads high unless a party pulls it low.
    assign sda_in = sda_drv_q & ~sda_oe;
    initial scl_in = 1'b1;
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Data moves two cycles after the clock falls, so it never looks like a start or stop.
    task automatic bit_io(input logic b, output logic s);
        sda_drv_q = b;
        tick(8);
        scl_in = 1'b1;
        tick(8);
        s = sda_in;
        scl_in = 1'b0;
        tick(2);
    endtask
    task automatic start();
        sda_drv_q = 1'b1;
        tick(8);
        scl_in = 1'b1;
        tick(8);
        sda_drv_q = 1'b0;
        tick(8);
        scl_in = 1'b0;
        tick(2);
    endtask
    task automatic stop();
        sda_drv_q = 1'b0;
        tick(8);
        scl_in = 1'b1;
        tick(8);
        sda_drv_q = 1'b1;
        tick(8);
    endtask
    task automatic send_byte(input logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(v[i], s);
        bit_io(1'b1, s);
        nack_q |= s;
    endtask
    task automatic recv_byte(input logic last, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            v[i] = s;
        end
        bit_io(last, s);
    endtask
    task automatic write_word(input logic [7:0] ptr, input logic [15:0] data);
        start();
        send_byte({`LSCC_DEV_ADDR, 1'b0});
        send_byte(ptr);
        send_byte(data[15:8]);
        send_byte(data[7:0]);
        stop();
    endtask
    task automatic read_words(input logic [7:0] ptr, input int n, output logic [31:0] d);
        logic [7:0] b;
        d = 32'h0;
        start();
        send_byte({`LSCC_DEV_ADDR, 1'b0});
        send_byte(ptr);
        start();
        send_byte({`LSCC_DEV_ADDR, 1'b1});
        for (int k = 0; k < 2 * n; k++) begin
            recv_byte(k == 2 * n - 1, b);
            d = {d[23:0], b};
        end
        stop();
    endtask
endmodule
`default_nettype wire

// File: bench/test_light_sensor_config_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "lscc_map.vh"
module test_light_sensor_config_control;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic irq_in = 1'b0;
    logic conv_done = 1'b0;
    logic flag_clear = 1'b0;
    logic [19:0] result_value = 20'h00050;
    logic [19:0] thresh_high = 20'h00100;
    logic [19:0] thresh_low = 20'h00010;
    logic [15:0] ext_rd_data = 16'h5a5a;
    wire logic scl_in, sda_in, sda_out, sda_oe, irq_out, irq_oe, conv_start, auto_range;
    wire logic ext_rd_strobe, ext_wr_strobe, standby_keep_powered, flag_high, flag_low;
    wire logic [7:0] reg_pointer;
    wire logic [15:0] ext_wr_data;
    wire logic [3:0] full_scale_select, integration_period_sel;
    wire logic [1:0] op_state_select;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;

    lscc_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .irq_in(irq_in), .irq_out(irq_out),
        .irq_oe(irq_oe), .conv_done(conv_done), .result_value(result_value),
        .thresh_high(thresh_high), .thresh_low(thresh_low), .flag_clear(flag_clear),
        .ext_rd_data(ext_rd_data), .reg_pointer(reg_pointer), .ext_rd_strobe(ext_rd_strobe),
        .ext_wr_strobe(ext_wr_strobe), .ext_wr_data(ext_wr_data),
        .full_scale_select(full_scale_select), .auto_range(auto_range),
        .integration_period_sel(integration_period_sel), .op_state_select(op_state_select),
        .conv_start(conv_start), .standby_keep_powered(standby_keep_powered),
        .flag_high(flag_high), .flag_low(flag_low));
    lscc_host_model host (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));

    task automatic stop_test();
        if (errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic hit(input logic [19:0] v);
        result_value = v;
        conv_done = 1'b1;
        tick(1);
        conv_done = 1'b0;
        tick(4);
    endtask
    // Bit 14 is always written as zero.
    function automatic logic [15:0] cfg_word(input logic qw, input logic [3:0] fs, tp,
            input logic [1:0] op, input logic pol, input logic [1:0] pc);
        return {qw, 1'b0, fs, tp, op, 1'b1, pol, pc};
    endfunction
    function automatic logic [15:0] irq_word(input logic dir, input logic [1:0] ev);
        return {11'h400, dir, ev, 1'b0, 1'b1};
    endfunction

    task automatic test_reset_values();
        logic [31:0] d;
        host.read_words(`LSCC_PTR_CFG, 2, d);
        check(d, {`LSCC_CFG_RST, `LSCC_IRQ_RST});
        check({24'h0, reg_pointer}, 32'h0000000c);
        check({20'h0, full_scale_select, integration_period_sel, op_state_select, auto_range,
            irq_oe}, {20'h0, 4'hc, 4'h8, 2'h0, 1'b1, 1'b1});
    endtask
    task automatic test_fields();
        logic [3:0] tp;
        logic [1:0] op;
        logic [15:0] w;
        logic [31:0] d;
        for (int i = 0; i < 13; i++) begin
            tp = (i > 11) ? 4'hb : i[3:0];
            op = i[1:0];
            w = cfg_word(i[0], i[3:0], tp, op, 1'b0, 2'h0);
            host.write_word(`LSCC_PTR_CFG, w);
            check({20'h0, standby_keep_powered, auto_range, full_scale_select,
                integration_period_sel, op_state_select}, {20'h0, i[0] && (op == 1 || op == 2),
                i == 12 || op == 1, i[3:0], tp, op});
        end
        host.read_words(`LSCC_PTR_CFG, 1, d);
        check(d, {16'h0, w});
        host.read_words(`LSCC_PTR_IRQ, 2, d);
        check(d, {`LSCC_IRQ_RST, 16'h5a5a});
    endtask
    task automatic test_persist();
        int n;
        host.write_word(`LSCC_PTR_IRQ, irq_word(1'b1, `LSCC_EV_ALERT));
        for (int c = 0; c < 4; c++) begin
            n = 1 << c;
            host.write_word(`LSCC_PTR_CFG,
                cfg_word(1'b0, 4'hc, 4'h8, `LSCC_OP_CONT, 1'b1, c[1:0]));
            hit(20'h00050);
            flag_clear = 1'b1;
            tick(1);
            flag_clear = 1'b0;
            repeat (n - 1) hit(20'h00200);
            check({30'h0, flag_high, flag_low}, 32'h0);
            hit(20'h00200);
            check({30'h0, flag_high, flag_low}, 32'h2);
            repeat (n - 1) hit(20'h00008);
            check({30'h0, flag_high, flag_low}, 32'h2);
            hit(20'h00008);
            check({30'h0, flag_high, flag_low}, 32'h3);
            check({31'h0, irq_out}, 32'h1);
        end
        result_value = 20'h00050;
    endtask
    task automatic test_irq_events();
        int act;
        for (int p = 0; p < 2; p++) begin
            for (int e = 1; e < 4; e++) begin
                host.write_word(`LSCC_PTR_CFG,
                    cfg_word(1'b0, 4'hc, 4'h8, `LSCC_OP_CONT, p[0], 2'h0));
                host.write_word(`LSCC_PTR_IRQ, irq_word(1'b1, e[1:0]));
                check({31'h0, irq_out}, {31'h0, ~p[0]});
                act = 0;
                repeat (4) begin
                    conv_done = 1'b1;
                    repeat (70) begin
                        tick(1);
                        conv_done = 1'b0;
                        if (irq_out === p[0]) act++;
                    end
                end
                check(act, (e == 1) ? 200 : (e == 3) ? 50 : 0);
            end
        end
    endtask
    task automatic test_trigger();
        int n;
        host.write_word(`LSCC_PTR_IRQ, irq_word(1'b0, `LSCC_EV_EVERY));
        host.write_word(`LSCC_PTR_CFG,
            cfg_word(1'b1, 4'h3, 4'h0, `LSCC_OP_ONESHOT, 1'b1, 2'h0));
        check({30'h0, irq_oe, standby_keep_powered}, 32'h1);
        tick(20);
        irq_in = 1'b1;
        n = 0;
        repeat (12) begin
            tick(1);
            if (conv_start === 1'b1) n++;
        end
        irq_in = 1'b0;
        check(n, 1);
    endtask

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            stop_test();
        end
    end
    initial begin
        tick(6);
        rst_b = 1'b1;
        tick(8);
        test_reset_values();
        test_fields();
        test_persist();
        test_irq_events();
        test_trigger();
        check({31'h0, host.nack_q}, 32'h0);
        stop_test();
    end
endmodule

bind lscc_top lscc_checker u_checker (.sys_clk(sys_clk), .rst_b(rst_b),
    .conv_done(conv_done), .result_value(result_value), .thresh_high(thresh_high),
    .thresh_low(thresh_low), .flag_clear(flag_clear), .full_scale_select(full_scale_select),
    .auto_range(auto_range), .op_state_select(op_state_select), .conv_start(conv_start),
    .standby_keep_powered(standby_keep_powered), .flag_high(flag_high), .flag_low(flag_low));
`default_nettype wire
